// ==== bench/ahe_probe_model.sv ====
// Purpose: Probe side model that feeds captured states to the engine
// Assumes: One state per clock at most, driven just after the rising edge
// Notes:   Lines are scrambled in idle cycles so stale values never match
`timescale 1ns/100ps
module ahe_probe_model
  import ahe_pkg::*;
(
  // Clock
  input  wire logic          clk_sys_i,
  // Captured state stream
  output logic               smp_valid_o,
  output logic      [DW-1:0] smp_label_o,
  output logic      [DW-1:0] smp_all_o,
  output logic      [DW-1:0] smp_tag_o,
  output logic               acq_end_o
);
  // Quiet lines at time zero
  initial begin
    smp_valid_o = 1'h0;
    smp_label_o = '0;
    smp_all_o   = '0;
    smp_tag_o   = '0;
    acq_end_o   = 1'h0;
  end

  // One captured state with its time tag; calls may follow back to back
  task automatic send(input logic [DW-1:0] lbl, input logic [DW-1:0] all, input logic [DW-1:0] tag);
    @(posedge clk_sys_i);
    smp_valid_o <= 1'h1;
    smp_label_o <= lbl;
    smp_all_o   <= all;
    smp_tag_o   <= tag;
  endtask : send

  // No state: invert the lines so an old value cannot be reused
  task automatic idle();
    @(posedge clk_sys_i);
    smp_valid_o <= 1'h0;
    smp_label_o <= ~smp_label_o;
    smp_all_o   <= ~smp_all_o;
    smp_tag_o   <= ~smp_tag_o;
    acq_end_o   <= 1'h0;
  endtask : idle

  // Close the acquisition with a one-cycle pulse; the last state must not repeat
  task automatic close_acq();
    @(posedge clk_sys_i);
    smp_valid_o <= 1'h0;
    acq_end_o   <= 1'h1;
    @(posedge clk_sys_i);
    acq_end_o   <= 1'h0;
  endtask : close_acq
endmodule : ahe_probe_model

// ==== bench/test_activity_histogram_engine.sv ====
// Purpose: Self-checking bench for the activity histogram engine
// Assumes: Register reads answer in the cycle after the strobe
// Notes:   Each view is run from a fresh measurement start
`timescale 1ns/100ps
module test_activity_histogram_engine;
  import ahe_pkg::*;
  // Design signals
  logic          clk_sys_i, resetn_i, wr_i, rd_i, half_chan_i;
  logic [AW-1:0] addr_i;
  logic [DW-1:0] wdata_i, rdata_o, smp_label, smp_all, smp_tag;
  logic          smp_valid, acq_end, running_o, warn_o;
  int            num_errors = 0;   // Mismatches seen
  int            n_checks   = 0;   // Comparisons made
  logic [DW-1:0] lo_tab [3] = '{32'hA, 32'hF, 32'h28};   // Range low bounds
  logic [DW-1:0] hi_tab [3] = '{32'h14, 32'h1E, 32'h32}; // Range high bounds

  ahe_engine uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .smp_valid_i(smp_valid), .smp_label_i(smp_label),
    .smp_all_i(smp_all), .smp_tag_i(smp_tag), .acq_end_i(acq_end), .half_chan_i(half_chan_i),
    .running_o(running_o), .warn_o(warn_o));
  ahe_probe_model probe (.clk_sys_i(clk_sys_i), .smp_valid_o(smp_valid), .smp_label_o(smp_label),
    .smp_all_o(smp_all), .smp_tag_o(smp_tag), .acq_end_o(acq_end));

  // 40 MHz clock
  initial begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Compare one value
  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One-cycle register write
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk_sys_i);
    wr_i    <= 1'h0;
  endtask : wr

  // Register read, data taken in the following cycle only
  task automatic chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk_sys_i);
    rd_i   <= 1'h0;
    #1 cmp(rdata_o, exp);
  endtask : chk

  // Address of element i of an array block
  function automatic logic [AW-1:0] ea(input logic [5:0] blk, input int i);
    ea = {blk, 4'(i), 2'h0};
  endfunction : ea

  // Hang guard, far beyond the roughly 160 cycles the tests take
  initial begin
    #500000;
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    {resetn_i, wr_i, rd_i, half_chan_i} = '0;
    addr_i  = '0;
    wdata_i = '0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    chk(A_CTRL, 32'h0);
    chk(12'h0FC, 32'h0);
    // Overview, span 1100: width 5, 220 buckets
    wr(A_LOW, 32'h0);
    wr(A_HIGH, 32'h44C);
    wr(A_CTRL, 32'h3);
    chk(A_WIDTH, 32'h5);
    chk(A_NBKT, 32'hDC);
    probe.send(32'h7, 32'h0, 32'h0);
    probe.send(32'h7, 32'h0, 32'h0);
    probe.send(32'h8, 32'h0, 32'h0);
    probe.send(32'h4B0, 32'h0, 32'h0);
    probe.send(32'h0, 32'h0, 32'h0);
    probe.close_acq();
    chk({B_BKT, 8'h01, 2'h0}, 32'h3);
    chk({B_BKT, 8'h00, 2'h0}, 32'h1);
    chk(A_TOTAL, 32'h4);
    chk(A_MAXC, 32'h3);
    wr(A_MRKX, 32'h1);
    wr(A_MRKO, 32'h0);
    chk(A_CNTX, 32'h3);
    chk(A_CNTO, 32'h1);
    // Small span: one bucket per value
    wr(A_CTRL, 32'h0);
    wr(A_HIGH, 32'h64);
    wr(A_CTRL, 32'h3);
    chk(A_NBKT, 32'h64);
    chk(A_WIDTH, 32'h1);
    // Setting change while running halts and warns
    wr(A_LOW, 32'h1);
    @(posedge clk_sys_i);
    #1 cmp({31'h0, running_o}, 32'h0);
    cmp({31'h0, warn_o}, 32'h1);
    // Range view: overlap, disabled range, other bin, qualifier
    wr(A_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ea(B_RLO, i), lo_tab[i]);
      wr(ea(B_RHI, i), hi_tab[i]);
    end
    wr(A_REN, 32'h3);
    wr(A_QVAL, 32'h1);
    wr(A_QMSK, 32'h1);
    wr(A_CTRL, 32'h37);
    #1 cmp({31'h0, warn_o}, 32'h0);
    probe.send(32'hF, 32'h1, 32'h0);
    probe.send(32'h14, 32'h1, 32'h0);
    probe.send(32'h2D, 32'h1, 32'h0);
    probe.send(32'h64, 32'h1, 32'h0);
    probe.send(32'h64, 32'h0, 32'h0);
    probe.idle();
    chk(ea(B_RCNT, 0), 32'h2);
    chk(ea(B_RCNT, 1), 32'h2);
    chk(ea(B_RCNT, 2), 32'h0);
    chk(A_OTHER, 32'h2);
    chk(A_TOTAL, 32'h4);
    chk(ea(B_RPCT, 0), 32'h32);
    chk(ea(B_RLO, 2), 32'h28);
    chk(ea(B_RHI, 2), 32'h32);
    // Interval view: boundary, repeated start, missing halves
    wr(A_CTRL, 32'h34);
    wr(A_CTRL, 32'h0);
    wr(A_SVAL, 32'h10);
    wr(A_SMSK, 32'hFF);
    wr(A_EVAL, 32'h20);
    wr(A_EMSK, 32'hFF);
    wr(ea(B_IHI, 0), 32'hA);
    wr(ea(B_ILO, 1), 32'hA);
    wr(ea(B_IHI, 1), 32'h14);
    wr(A_CTRL, 32'hB);
    probe.send(32'h0, 32'h10, 32'h64);
    probe.send(32'h0, 32'h10, 32'h69);
    probe.send(32'h0, 32'h20, 32'h6E);
    probe.close_acq();
    probe.send(32'h0, 32'h10, 32'hC8);
    probe.close_acq();
    probe.send(32'h0, 32'h20, 32'h12C);
    probe.close_acq();
    half_chan_i <= 1'h1;
    probe.send(32'h0, 32'h10, 32'h190);
    probe.send(32'h0, 32'h20, 32'h195);
    probe.close_acq();
    chk(A_ITOT, 32'h1);
    chk(ea(B_ICNT, 0), 32'h0);
    chk(ea(B_ICNT, 1), 32'h1);
    chk(ea(B_ICNT, 2), 32'h0);
    wr(A_CTRL, 32'hB);
    chk(A_ITOT, 32'h0);
    conclude();
  end
endmodule : test_activity_histogram_engine

// ==== core/ahe_engine.sv ====
// Purpose: Activity histogram engine: overview, range and interval views
// Assumes: Samples arrive one per cycle, acq_end_i closes an acquisition
// Notes:   Sorting is done per sample, so the blind time is zero
//
// Summary of operation
// R1: Span splits into 256 buckets, width rounded up
// R2: Span below 255 uses span as bucket count
// R3: Sort every sample, repeat until stopped
// R4: Report largest bucket count after each acquisition
// R5: Total count of sampled states since start
// R6: Two markers select buckets and report counts
// R7: Overview drops samples outside low-high span
// R8: Eleven ranges, inclusive bounds, counted when enabled
// R9: Overlapping ranges all count the sample
// R10: Disabled range keeps its bounds
// R11: Total counts sample once, other when included
// R12: Unmatched samples go to the other bin
// R13: Range count reported as percent of total
// R14: Qualified tracing drops unmatched pattern samples
// R15: Interval timed from start to end pattern
// R16: Repeated starts ignored until end arrives
// R17: Incomplete pair leaves interval histogram unchanged
// R18: Duration on shared boundary goes higher range
// R19: Half-channel mode disables interval timing
// R20: Eight interval ranges with lower, upper limits
// R21: Critical change while running halts, raises warning
// R22: Interval range with zero limits is disabled
// R23: Start of measurement clears all counters
// R24: Counters saturate instead of wrapping
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module ahe_engine
  import ahe_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  // Register port
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  // Sample stream from the probes
  input  wire logic          smp_valid_i,
  input  wire logic [DW-1:0] smp_label_i,
  input  wire logic [DW-1:0] smp_all_i,
  input  wire logic [DW-1:0] smp_tag_i,
  input  wire logic          acq_end_i,
  input  wire logic          half_chan_i,
  // Status
  output logic               running_o,
  output logic               warn_o
);

  // Whole state of the engine
  typedef struct packed {
    ahe_run_type               rs;      // Acquisition state
    logic [1:0]                view;    // Selected view
    logic                      oth;     // Other states included
    logic                      qual;    // Qualified tracing
    logic [DW-1:0]             low;     // Overview low value
    logic [DW-1:0]             high;    // Overview high value
    logic [DW-1:0]             qv;      // Qualifier value
    logic [DW-1:0]             qm;      // Qualifier care mask
    logic [DW-1:0]             sv;      // Start pattern value
    logic [DW-1:0]             sm;      // Start care mask
    logic [DW-1:0]             ev;      // End pattern value
    logic [DW-1:0]             em;      // End care mask
    logic [NRG-1:0]            ren;     // Range enables
    logic [NRG-1:0][DW-1:0]    rlo;     // Range low bounds
    logic [NRG-1:0][DW-1:0]    rhi;     // Range high bounds
    logic [NRG-1:0][DW-1:0]    rcnt;    // Range counts
    logic [DW-1:0]             other;   // Other bin
    logic [DW-1:0]             total;   // Total count of current view
    logic [NBK-1:0][DW-1:0]    bkt;     // Bucket counts
    logic [DW-1:0]             runmax;  // Running largest bucket
    logic [DW-1:0]             maxcnt;  // Reported largest bucket
    logic [7:0]                mx;      // X marker bucket
    logic [7:0]                mo;      // O marker bucket
    logic [NIV-1:0][DW-1:0]    ilo;     // Interval lower limits
    logic [NIV-1:0][DW-1:0]    ihi;     // Interval upper limits
    logic [NIV-1:0][DW-1:0]    icnt;    // Interval counts
    logic [DW-1:0]             itot;    // Start/end pairs sorted
    logic                      armed;   // Start seen, waiting end
    logic [DW-1:0]             tstart;  // Time tag of first start
    logic                      warn;    // Halted by setting change
    logic [DW-1:0]             rdata;   // Read data register
  } ahe_state_type;

  ahe_state_type q;                     // Registered state
  ahe_state_type nx;                    // Next state

  // Decode and datapath terms
  logic            clr;                 // Start measurement
  logic            crit;                // Critical write while running
  logic            acc;                 // Sample accepted for sorting
  logic [DW:0]     span;                // High minus low
  logic [DW-1:0]   width;               // Bucket width
  logic [DW-1:0]   nbkt;                // Buckets in use
  logic [DW-1:0]   off;                 // Sample minus low
  logic [DW-1:0]   bidx;                // Bucket of the sample
  logic            inspan;              // Sample within low-high
  logic [NRG-1:0]  hit;                 // Ranges containing sample
  logic            qok;                 // Qualifier matched
  logic            smatch;              // Start pattern matched
  logic            ematch;              // End pattern matched
  logic [DW-1:0]   dur;                 // Measured duration
  logic [NIV-1:0]  ien;                 // Interval range enabled
  logic [NIV-1:0]  ihit;                // Interval ranges hit
  logic [5:0]      blk;                 // Array block select
  logic [3:0]      el;                  // Array element index
  logic            cfgw;                // Write to a config register

  // Next-state logic
  always_comb begin
    nx       = q;
    nx.rdata = '0;
    blk      = addr_i[11:6];
    el       = addr_i[5:2];
    clr      = wr_i && addr_i == A_CTRL && wdata_i[C_CLR];

    // Bucket scaling; a divider handles any span, the last bucket takes the remainder
    span  = {1'b0, q.high} - {1'b0, q.low};
    if (span < SPAN_SMALL) begin
      width = 32'h1;                                         // R2
      nbkt  = (span[DW-1:0] == '0) ? 32'h1 : span[DW-1:0];   // R2
    end else begin
      width = 32'((span + BKT_ROUND) >> BKT_SHIFT);          // R1
      nbkt  = span[DW-1:0] / width;                          // R1
    end
    inspan = smp_label_i >= q.low && smp_label_i <= q.high;  // R7
    off    = smp_label_i - q.low;
    bidx   = off / width;
    if (bidx >= nbkt) begin
      bidx = nbkt - 32'h1;                                   // R1
    end

    // Pattern matches over all labels, mask bit set means care
    qok    = !q.qual || ((smp_all_i ^ q.qv) & q.qm) == '0;   // R14
    smatch = ((smp_all_i ^ q.sv) & q.sm) == '0;              // R15
    ematch = ((smp_all_i ^ q.ev) & q.em) == '0;              // R15

    // Range hits; disabled ranges keep bounds but never match
    for (int i = 0; i < NRG; i++) begin
      hit[i] = q.ren[i] && smp_label_i >= q.rlo[i]
               && smp_label_i <= q.rhi[i];                   // R8 R10
    end

    // Interval range hits, boundary goes to the higher range
    dur = smp_tag_i - q.tstart;                              // R15
    for (int i = 0; i < NIV; i++) begin
      ien[i]  = !(q.ilo[i] == '0 && q.ihi[i] == '0);         // R22
      ihit[i] = ien[i] && dur >= q.ilo[i] && dur <= q.ihi[i]; // R20
    end
    for (int i = 0; i < NIV; i++) begin
      for (int j = 0; j < NIV; j++) begin
        if (j != i && ien[j] && dur == q.ihi[i] && q.ilo[j] == dur) begin
          ihit[i] = 1'b0;                                    // R18
        end
      end
    end

    // Writes to configuration that a running measurement depends on
    cfgw = wr_i && ((addr_i >= A_LOW && addr_i <= A_REN)
           || blk == B_RLO || blk == B_RHI
           || blk == B_ILO || blk == B_IHI
           || (addr_i == A_CTRL
               && (wdata_i[C_VIEW+:2] != q.view
                   || wdata_i[C_QUAL] != q.qual
                   || wdata_i[C_OTH] != q.oth)));
    crit = cfgw && q.rs == RS_RUN;

    // Register writes
    if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          nx.view = wdata_i[C_VIEW+:2];
          nx.oth  = wdata_i[C_OTH];
          nx.qual = wdata_i[C_QUAL];
          nx.rs   = wdata_i[C_RUN] ? RS_RUN : RS_IDLE;       // R3
        end
        A_LOW:  nx.low  = wdata_i;
        A_HIGH: nx.high = wdata_i;
        A_QVAL: nx.qv   = wdata_i;
        A_QMSK: nx.qm   = wdata_i;
        A_SVAL: nx.sv   = wdata_i;
        A_SMSK: nx.sm   = wdata_i;
        A_EVAL: nx.ev   = wdata_i;
        A_EMSK: nx.em   = wdata_i;
        A_REN:  nx.ren  = wdata_i[NRG-1:0];                  // R10
        A_MRKX: nx.mx   = wdata_i[7:0];                      // R6
        A_MRKO: nx.mo   = wdata_i[7:0];                      // R6
        default: begin
          if (blk == B_RLO && el < NRG) nx.rlo[el] = wdata_i;
          if (blk == B_RHI && el < NRG) nx.rhi[el] = wdata_i;
          if (blk == B_ILO && el < NIV) nx.ilo[el[2:0]] = wdata_i;
          if (blk == B_IHI && el < NIV) nx.ihi[el[2:0]] = wdata_i;
        end
      endcase
    end
    if (crit) begin
      nx.rs   = RS_IDLE;                                     // R21
      nx.warn = 1'b1;                                        // R21
    end

    // Sorting of accepted samples
    acc = q.rs == RS_RUN && smp_valid_i && !crit;            // R3
    if (acc) begin
      unique case (q.view)
        V_OVR: begin
          if (inspan) begin                                  // R7
            nx.bkt[bidx[7:0]] = ahe_sat(q.bkt[bidx[7:0]]);   // R3 R24
            nx.total = ahe_sat(q.total);                     // R5
            if (nx.bkt[bidx[7:0]] > q.runmax) begin
              nx.runmax = nx.bkt[bidx[7:0]];                 // R4
            end
          end
        end
        V_RNG: begin
          if (qok) begin                                     // R14
            for (int i = 0; i < NRG; i++) begin
              if (hit[i]) nx.rcnt[i] = ahe_sat(q.rcnt[i]);   // R8 R9
            end
            if (hit == '0) nx.other = ahe_sat(q.other);      // R12
            if (hit != '0 || q.oth) nx.total = ahe_sat(q.total); // R11
          end
        end
        V_IVL: begin
          if (!half_chan_i) begin                            // R19
            if (q.armed && ematch) begin
              nx.armed = 1'b0;                               // R16
              nx.itot  = ahe_sat(q.itot);                    // R17
              for (int i = 0; i < NIV; i++) begin
                if (ihit[i]) nx.icnt[i] = ahe_sat(q.icnt[i]); // R17
              end
            end else if (!q.armed && smatch) begin
              nx.armed  = 1'b1;                              // R16
              nx.tstart = smp_tag_i;                         // R16
            end
          end
        end
        default: ;
      endcase
    end

    // End of acquisition: report maximum, drop an unpaired start
    if (acq_end_i) begin
      nx.maxcnt = nx.runmax;                                 // R4
      nx.armed  = 1'b0;                                      // R17
    end
    if (half_chan_i) begin
      nx.armed = 1'b0;                                       // R19
    end

    // Start of a new measurement clears every counter
    if (clr) begin
      nx.bkt    = '0;                                        // R23
      nx.rcnt   = '0;                                        // R23
      nx.icnt   = '0;
      nx.other  = '0;                                        // R23
      nx.total  = '0;                                        // R23
      nx.itot   = '0;
      nx.runmax = '0;
      nx.maxcnt = '0;
      nx.armed  = 1'b0;
      // A halting write in the same cycle keeps its warning
      nx.warn   = crit;                                      // R21
    end

    // Read data for the cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        A_CTRL:  nx.rdata = DW'({q.qual, q.oth, q.view, 1'b0,
                                 q.rs == RS_RUN});
        A_STAT:  nx.rdata = DW'({q.armed, q.warn, q.rs == RS_RUN});
        A_LOW:   nx.rdata = q.low;
        A_HIGH:  nx.rdata = q.high;
        A_QVAL:  nx.rdata = q.qv;
        A_QMSK:  nx.rdata = q.qm;
        A_SVAL:  nx.rdata = q.sv;
        A_SMSK:  nx.rdata = q.sm;
        A_EVAL:  nx.rdata = q.ev;
        A_EMSK:  nx.rdata = q.em;
        A_REN:   nx.rdata = DW'(q.ren);
        A_MRKX:  nx.rdata = DW'(q.mx);
        A_MRKO:  nx.rdata = DW'(q.mo);
        A_CNTX:  nx.rdata = q.bkt[q.mx];                     // R6
        A_CNTO:  nx.rdata = q.bkt[q.mo];                     // R6
        A_MAXC:  nx.rdata = q.maxcnt;                        // R4
        A_TOTAL: nx.rdata = q.total;                         // R5
        A_OTHER: nx.rdata = q.other;                         // R12
        A_WIDTH: nx.rdata = width;                           // R1
        A_NBKT:  nx.rdata = nbkt;                            // R2
        A_ITOT:  nx.rdata = q.itot;
        default: begin
          if (addr_i[11:10] == B_BKT) nx.rdata = q.bkt[addr_i[9:2]];
          if (blk == B_RLO && el < NRG) nx.rdata = q.rlo[el];
          if (blk == B_RHI && el < NRG) nx.rdata = q.rhi[el];
          if (blk == B_RCNT && el < NRG) nx.rdata = q.rcnt[el];
          if (blk == B_RPCT && el < NRG) begin
            nx.rdata = ahe_pct(q.rcnt[el], q.total);         // R13
          end
          if (blk == B_ILO && el < NIV) nx.rdata = q.ilo[el[2:0]];
          if (blk == B_IHI && el < NIV) nx.rdata = q.ihi[el[2:0]];
          if (blk == B_ICNT && el < NIV) nx.rdata = q.icnt[el[2:0]];
        end
      endcase
    end
  end

  // State register; reset puts the engine idle with empty counters
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q    <= '0;
      q.rs <= RS_IDLE;
    end else begin
      q <= nx;
    end
  end

  // Outputs straight from the state register
  assign rdata_o   = q.rdata;
  assign running_o = q.rs[1];           // One-hot run bit, no gate after the flop
  assign warn_o    = q.warn;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_total_sat_hold: assert property ((q.total == '1 && !clr) |=> q.total == '1) // R24
    else $error("total counter wrapped");
  a_crit_halt_warn: assert property (crit |=> (q.rs == RS_IDLE && warn_o)) // R21
    else $error("setting change did not halt");
  a_clear_counters: assert property (clr |=> (q.total == '0 && q.other == '0 && q.rcnt == '0)) // R23
    else $error("counters not cleared");
  a_other_bin_step: assert property ((acc && !clr && q.view == V_RNG && qok && hit == '0) // R12
    |=> q.other == ahe_sat($past(q.other)))
    else $error("other bin missed sample");
  a_total_once: assert property ((acc && !clr && q.view == V_RNG && qok && hit != '0) // R11
    |=> q.total == ahe_sat($past(q.total)))
    else $error("total not stepped once");
  a_qual_drop: assert property ((acc && q.view == V_RNG && !qok && !clr) // R14
    |=> (q.other == $past(q.other) && q.total == $past(q.total)))
    else $error("unqualified sample counted");
  a_outside_drop: assert property ((acc && q.view == V_OVR && !inspan && !clr) // R7
    |=> q.total == $past(q.total))
    else $error("out of span sample counted");
  a_half_disarm: assert property (half_chan_i |=> !q.armed) // R19
    else $error("interval armed in half channel");
  a_start_kept: assert property ((acc && q.view == V_IVL && q.armed && !ematch // R16
    && !acq_end_i && !half_chan_i && !clr) |=> (q.armed && $stable(q.tstart)))
    else $error("repeated start restarted timer");
  a_max_report: assert property ((acq_end_i && !clr) // R4
    |=> (q.maxcnt == q.runmax && q.maxcnt >= q.bkt[q.mx]))
    else $error("max count not reported");
  a_read_total: assert property ((rd_i && addr_i == A_TOTAL) |=> rdata_o == $past(q.total)) // R5
    else $error("total read wrong");
  // Counters move only while a run sorts samples
  a_idle_no_sort: assert property ((q.rs == RS_IDLE && !clr) // R3
    |=> (q.total == $past(q.total) && q.other == $past(q.other) && q.itot == $past(q.itot)))
    else $error("counter moved while idle");
  // Overlapping ranges must both take the sample
  a_range_overlap: assert property ((acc && !clr && q.view == V_RNG && qok && hit[0] && hit[1]) // R9
    |=> (q.rcnt[0] == ahe_sat($past(q.rcnt[0])) && q.rcnt[1] == ahe_sat($past(q.rcnt[1]))))
    else $error("overlapping range missed sample");
  // The last interval range, with both limits zero, never counts
  a_off_range_hold: assert property ((q.ilo[NIV-1] == '0 && q.ihi[NIV-1] == '0 && !clr) // R22
    |=> q.icnt[NIV-1] == $past(q.icnt[NIV-1]))
    else $error("disabled interval range counted");
  // Warning stays until the next measurement start
  a_warn_sticky: assert property ((warn_o && !clr) |=> warn_o) // R21
    else $error("warning dropped without clear");
endmodule : ahe_engine

// ==== core/ahe_pkg.sv ====
// Purpose: Constants and helpers for the activity histogram engine
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Offsets are byte addresses; array blocks use addr[11:6], the bucket block addr[11:10]
package ahe_pkg;
  // Sizes
  localparam int AW  = 12;                 // Register address width
  localparam int DW  = 32;                 // Data and counter width
  localparam int NBK = 256;                // Overview buckets
  localparam int NRG = 11;                 // Range histogram ranges
  localparam int NIV = 8;                  // Interval ranges
  // Single registers
  localparam logic [AW-1:0] A_CTRL  = 12'h000;
  localparam logic [AW-1:0] A_STAT  = 12'h004;
  localparam logic [AW-1:0] A_LOW   = 12'h008;
  localparam logic [AW-1:0] A_HIGH  = 12'h00C;
  localparam logic [AW-1:0] A_QVAL  = 12'h010;
  localparam logic [AW-1:0] A_QMSK  = 12'h014;
  localparam logic [AW-1:0] A_SVAL  = 12'h018;
  localparam logic [AW-1:0] A_SMSK  = 12'h01C;
  localparam logic [AW-1:0] A_EVAL  = 12'h020;
  localparam logic [AW-1:0] A_EMSK  = 12'h024;
  localparam logic [AW-1:0] A_REN   = 12'h028;
  localparam logic [AW-1:0] A_MRKX  = 12'h02C;
  localparam logic [AW-1:0] A_MRKO  = 12'h030;
  localparam logic [AW-1:0] A_CNTX  = 12'h034;
  localparam logic [AW-1:0] A_CNTO  = 12'h038;
  localparam logic [AW-1:0] A_MAXC  = 12'h03C;
  localparam logic [AW-1:0] A_TOTAL = 12'h040;
  localparam logic [AW-1:0] A_OTHER = 12'h044;
  localparam logic [AW-1:0] A_WIDTH = 12'h048;
  localparam logic [AW-1:0] A_NBKT  = 12'h04C;
  localparam logic [AW-1:0] A_ITOT  = 12'h050;
  // Array blocks, element index in addr[5:2], bucket index in addr[9:2]
  localparam logic [5:0] B_RLO  = 6'h04;   // 0x100 range low bounds
  localparam logic [5:0] B_RHI  = 6'h05;   // 0x140 range high bounds
  localparam logic [5:0] B_RCNT = 6'h06;   // 0x180 range counts
  localparam logic [5:0] B_RPCT = 6'h07;   // 0x1C0 range percent
  localparam logic [5:0] B_ILO  = 6'h08;   // 0x200 interval lower
  localparam logic [5:0] B_IHI  = 6'h09;   // 0x240 interval upper
  localparam logic [5:0] B_ICNT = 6'h0A;   // 0x280 interval counts
  localparam logic [1:0] B_BKT  = 2'h1;    // 0x400..0x7FC bucket counts
  // Control fields
  localparam int C_RUN  = 0;               // Run while set
  localparam int C_CLR  = 1;               // Start measurement, write 1
  localparam int C_VIEW = 2;               // Two-bit view select
  localparam int C_OTH  = 4;               // Other states included
  localparam int C_QUAL = 5;               // Qualified tracing
  // Status fields
  localparam int S_RUN  = 0;
  localparam int S_WARN = 1;
  localparam int S_ARM  = 2;
  // View codes
  localparam logic [1:0] V_OVR = 2'h0;
  localparam logic [1:0] V_RNG = 2'h1;
  localparam logic [1:0] V_IVL = 2'h2;
  // Scaling
  localparam logic [DW:0]   SPAN_SMALL = 33'h0000000FF;
  localparam logic [DW:0]   BKT_ROUND  = 33'h0000000FF;
  localparam int            BKT_SHIFT  = 8;
  localparam logic [63:0]   PCT_SCALE  = 64'h64;

  // Run state of the acquisition
  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_RUN  = 2'b10
  } ahe_run_type;

  // Occurrence counter step that sticks at all ones
  function automatic logic [DW-1:0] ahe_sat(input logic [DW-1:0] v);
    ahe_sat = (v == '1) ? v : v + 32'h1;
  endfunction : ahe_sat

  // Count as percent of total, zero when nothing was counted
  function automatic logic [DW-1:0] ahe_pct(input logic [DW-1:0] c,
                                            input logic [DW-1:0] t);
    logic [63:0] p;
    p = ({32'h0, c} * PCT_SCALE) / {32'h0, (t == '0) ? 32'h1 : t};
    ahe_pct = (t == '0) ? '0 : p[DW-1:0];
  endfunction : ahe_pct
endpackage : ahe_pkg
